// ===== verilog/pdwk_pkg.sv
// Package for the power-down and wakeup controller
package pdwk_pkg;
  // ----------------------------------------------------------------
  // Register indices on the plain software port
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_WAKE_EN = 4'h0;
  localparam logic [3:0] ADDR_WAKE_COND = 4'h1;
  localparam logic [3:0] ADDR_EXT_WAKE = 4'h2;
  localparam logic [3:0] ADDR_EXT_IRQ = 4'h3;
  localparam logic [3:0] ADDR_BIAS0 = 4'h4;
  localparam logic [3:0] ADDR_BIAS1 = 4'h5;
  localparam logic [3:0] ADDR_OUT_TYPE = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_CMD = 4'h8;
  localparam logic [3:0] ADDR_CNT_SEL = 4'h9;
  // ----------------------------------------------------------------
  // Command bits (write to ADDR_CMD)
  // ----------------------------------------------------------------
  localparam int CMD_ARM = 0;
  localparam int CMD_RUN = 1;
  localparam int CMD_HOLD = 2;
  localparam int CMD_WDKICK = 3;
  localparam int CMD_BO_ARM = 4;
  localparam int CMD_T3SET = 5;
  localparam int CMD_T3CLR = 6;
  // ----------------------------------------------------------------
  // Status bits and field positions
  // ----------------------------------------------------------------
  localparam int ST_WARM = 0;
  localparam int ST_T3F = 1;
  localparam int ST_MODE_LO = 2;
  localparam int ST_BO_ARMED = 4;
  localparam int ST_EXT0F = 5;
  localparam int EXTW_EN = 0;
  localparam int EXTW_EDGE = 1;
  localparam int EXTI_EDGE = 0;
  localparam int EXTI_GATE = 1;
  localparam int EXTI_LVL = 2;
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [2:0] STACK_HOLD_LVL = 3'h7;
  localparam logic [1:0] CNT_SEL_INPUT = 2'h3;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  typedef enum logic [1:0] {
    PDWK_RUN = 2'b00,
    PDWK_SLEEP_CLK = 2'b01,
    PDWK_SLEEP_HOLD = 2'b10
  } pdwk_state_type;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pdwk_bus_type;

  // State-initialise pulses toward the core
  typedef struct packed {
    logic cpu_init;
    logic irq_init;
    logic wdog_init;
    logic timers_undef;
    logic slow_timers_undef;
  } pdwk_init_type;
endpackage : pdwk_pkg

// ===== verilog/pdwk_ctrl.sv
// Power-down and wakeup controller for a small 4-bit core
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module pdwk_ctrl
  import pdwk_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire pdwk_bus_type bus_i,
  output logic [7:0] rdata_o,
  input wire logic [3:0] port_group_0_i,
  input wire logic [3:0] port_group_1_i,
  input wire logic int_pin_i,
  input wire logic timer3_underflow_i,
  output pdwk_init_type init_o,
  output logic [2:0] stack_level_init_o,
  output logic sleeping_o,
  output logic osc_stop_o,
  output logic warm_start_o,
  output logic timer3_request_flag_o,
  output logic brownout_active_o,
  output logic counter_io_pin_o,
  output logic counter_io_pin_oe_o,
  output logic [3:0] bias_ctrl_group0_o,
  output logic [3:0] bias_ctrl_group1_o,
  output logic [3:0] output_type_ctrl_o
);

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  pdwk_state_type state_q;
  logic [3:0] wake_enable_reg_q;
  logic [3:0] wake_cond_reg_q;
  logic [3:0] ext_wake_reg_q;
  logic [3:0] ext_irq_ctrl_q;
  logic [3:0] bias0_q;
  logic [3:0] bias1_q;
  logic [3:0] out_type_q;
  logic [1:0] cnt_sel_q;
  logic armed_q;
  logic warm_q;
  logic t3f_q;
  logic bo_arm_q;
  logic ext0f_q;
  logic [3:0] p0_q;
  logic [3:0] p1_q;
  logic int_q;
  logic wake;
  logic key_wake;
  logic int_edge_wake;
  logic int_lvl_wake;
  logic sleep_cmd;
  logic wr_cmd;

  assign wr_cmd = bus_i.wr && (bus_i.addr == ADDR_CMD);
  // Sleep op only acts right after the arm op
  assign sleep_cmd = wr_cmd && armed_q && state_q == PDWK_RUN
    && (bus_i.wdata[CMD_RUN] || bus_i.wdata[CMD_HOLD]);

  // ----------------------------------------------------------------
  // Wake detection
  // ----------------------------------------------------------------
  // Previous pin levels for edge detection
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      p0_q <= 4'hf;
      p1_q <= 4'hf; // Pulled-up idle level, no false edge
      int_q <= 1'b0;
    end
    else
    begin
      p0_q <= port_group_0_i;
      p1_q <= port_group_1_i;
      int_q <= int_pin_i;
    end
  end

  // Key wake per pin pair
  always_comb
  begin
    logic hit;
    hit = 1'b0;
    key_wake = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      // Group 0: fixed falling edge
      hit = |(p0_q[2*i +: 2] & ~port_group_0_i[2*i +: 2]);
      if (wake_enable_reg_q[i] && hit)
        key_wake = 1'b1;
      // Group 1: bit 2i polarity, bit 2i+1 level select
      if (wake_cond_reg_q[2*i+1])
        hit = wake_cond_reg_q[2*i] ? |port_group_1_i[2*i +: 2]
                                   : |(~port_group_1_i[2*i +: 2]);
      else if (wake_cond_reg_q[2*i])
        hit = |(~p1_q[2*i +: 2] & port_group_1_i[2*i +: 2]);
      else
        hit = |(p1_q[2*i +: 2] & ~port_group_1_i[2*i +: 2]);
      if (wake_enable_reg_q[2+i] && hit)
        key_wake = 1'b1;
    end
  end

  // Interrupt pin wake; level from interrupt ctrl, mode from ext wake
  assign int_lvl_wake = ext_wake_reg_q[EXTW_EN] && !ext_wake_reg_q[EXTW_EDGE]
    && ext_irq_ctrl_q[EXTI_GATE]
    && (int_pin_i == ext_irq_ctrl_q[EXTI_LVL]);
  assign int_edge_wake = ext_wake_reg_q[EXTW_EN] && ext_wake_reg_q[EXTW_EDGE]
    && ext_irq_ctrl_q[EXTI_GATE] && (int_q != int_pin_i)
    && (int_pin_i == ext_irq_ctrl_q[EXTI_LVL]);

  // Hold sleep ignores timer 3: oscillator is stopped
  assign wake = (state_q == PDWK_SLEEP_CLK
                 && (key_wake || int_lvl_wake || int_edge_wake
                     || t3f_q))
             || (state_q == PDWK_SLEEP_HOLD
                 && (key_wake || int_lvl_wake || int_edge_wake));

  // ----------------------------------------------------------------
  // Sleep state machine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      state_q <= PDWK_RUN;
    else
    begin
      case (state_q)
        PDWK_RUN:
          if (sleep_cmd)
            state_q <= bus_i.wdata[CMD_HOLD] ? PDWK_SLEEP_HOLD
                                             : PDWK_SLEEP_CLK;
        PDWK_SLEEP_CLK,
        PDWK_SLEEP_HOLD:
          if (wake)
            state_q <= PDWK_RUN;
        default:
          state_q <= PDWK_RUN;
      endcase
    end
  end

  // Arm op: cleared by any other command
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      armed_q <= 1'b0;
    else if (wr_cmd)
      armed_q <= bus_i.wdata[CMD_ARM];
  end

  // Warm indicator: wake sets, reset clears
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      warm_q <= 1'b0;
    else if (wake)
      warm_q <= 1'b1;
  end

  // Timer 3 flag: set wins over clear; kept across clock-run sleep
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      t3f_q <= 1'b0;
    else if ((timer3_underflow_i && state_q != PDWK_SLEEP_HOLD)
             || (wr_cmd && bus_i.wdata[CMD_T3SET]))
      t3f_q <= 1'b1;
    else if (wr_cmd && bus_i.wdata[CMD_T3CLR])
      t3f_q <= 1'b0;
  end

  // Brownout arm: once, until reset
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      bo_arm_q <= 1'b0;
    else if (wr_cmd && bus_i.wdata[CMD_BO_ARM])
      bo_arm_q <= 1'b1;
  end

  // External 0 request: edge sets, sleep entry clears, level wake not
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || sleep_cmd)
      ext0f_q <= 1'b0;
    else if (state_q == PDWK_RUN && ext_irq_ctrl_q[EXTI_GATE]
             && int_q != int_pin_i
             && int_pin_i == ext_irq_ctrl_q[EXTI_EDGE])
      ext0f_q <= 1'b1;
    else if (state_q != PDWK_RUN && int_edge_wake)
      ext0f_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Configuration registers, retained through sleep
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      wake_enable_reg_q <= RST_NIB;
      wake_cond_reg_q <= RST_NIB;
      ext_wake_reg_q <= RST_NIB;
      ext_irq_ctrl_q <= RST_NIB;
      bias0_q <= RST_NIB;
      bias1_q <= RST_NIB;
      out_type_q <= RST_NIB;
      cnt_sel_q <= 2'h0;
    end
    else if (bus_i.wr)
    begin
      if (bus_i.addr == ADDR_WAKE_EN)
        wake_enable_reg_q <= bus_i.wdata[3:0];
      else if (bus_i.addr == ADDR_WAKE_COND)
        wake_cond_reg_q <= bus_i.wdata[3:0];
      else if (bus_i.addr == ADDR_EXT_WAKE)
        ext_wake_reg_q <= bus_i.wdata[3:0];
      else if (bus_i.addr == ADDR_EXT_IRQ)
        ext_irq_ctrl_q <= bus_i.wdata[3:0];
      else if (bus_i.addr == ADDR_BIAS0)
        bias0_q <= bus_i.wdata[3:0];
      else if (bus_i.addr == ADDR_BIAS1)
        bias1_q <= bus_i.wdata[3:0];
      else if (bus_i.addr == ADDR_OUT_TYPE)
        out_type_q <= bus_i.wdata[3:0];
      else if (bus_i.addr == ADDR_CNT_SEL)
        cnt_sel_q <= bus_i.wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      rdata_o <= RD_UNMAPPED;
    else if (bus_i.rd)
    begin
      if (bus_i.addr == ADDR_WAKE_EN)
        rdata_o <= {4'h0, wake_enable_reg_q};
      else if (bus_i.addr == ADDR_WAKE_COND)
        rdata_o <= {4'h0, wake_cond_reg_q};
      else if (bus_i.addr == ADDR_EXT_WAKE)
        rdata_o <= {4'h0, ext_wake_reg_q};
      else if (bus_i.addr == ADDR_EXT_IRQ)
        rdata_o <= {4'h0, ext_irq_ctrl_q};
      else if (bus_i.addr == ADDR_BIAS0)
        rdata_o <= {4'h0, bias0_q};
      else if (bus_i.addr == ADDR_BIAS1)
        rdata_o <= {4'h0, bias1_q};
      else if (bus_i.addr == ADDR_OUT_TYPE)
        rdata_o <= {4'h0, out_type_q};
      else if (bus_i.addr == ADDR_CNT_SEL)
        rdata_o <= {6'h00, cnt_sel_q};
      else if (bus_i.addr == ADDR_STATUS)
        rdata_o <= {2'h0, ext0f_q, bo_arm_q, state_q,
                    t3f_q, warm_q};
      else
        rdata_o <= RD_UNMAPPED;
    end
    else
      rdata_o <= RD_UNMAPPED;
  end

  // ----------------------------------------------------------------
  // Outputs toward the core and pins
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      init_o <= '0;
      stack_level_init_o <= 3'h0;
      sleeping_o <= 1'b0;
      osc_stop_o <= 1'b0;
    end
    else
    begin
      init_o.cpu_init <= sleep_cmd;
      init_o.irq_init <= sleep_cmd;
      init_o.wdog_init <= sleep_cmd;
      init_o.timers_undef <= sleep_cmd;
      init_o.slow_timers_undef <= sleep_cmd
                                  && bus_i.wdata[CMD_HOLD];
      if (sleep_cmd && bus_i.wdata[CMD_HOLD])
        stack_level_init_o <= STACK_HOLD_LVL;
      else if (sleep_cmd)
        stack_level_init_o <= 3'h0;
      sleeping_o <= (state_q != PDWK_RUN && !wake) || sleep_cmd;
      osc_stop_o <= (state_q == PDWK_SLEEP_HOLD && !wake)
                    || (sleep_cmd && bus_i.wdata[CMD_HOLD]);
    end
  end

  // Status mirrors and pin control
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      warm_start_o <= 1'b0;
      timer3_request_flag_o <= 1'b0;
      brownout_active_o <= 1'b1;
      counter_io_pin_o <= 1'b0;
      counter_io_pin_oe_o <= 1'b0;
      bias_ctrl_group0_o <= RST_NIB;
      bias_ctrl_group1_o <= RST_NIB;
      output_type_ctrl_o <= RST_NIB;
    end
    else
    begin
      warm_start_o <= warm_q;
      timer3_request_flag_o <= t3f_q;
      // Detector runs when awake, or asleep only if armed
      brownout_active_o <= (state_q == PDWK_RUN) || bo_arm_q;
      counter_io_pin_o <= 1'b0;
      counter_io_pin_oe_o <= (state_q == PDWK_SLEEP_HOLD)
                             && (cnt_sel_q != CNT_SEL_INPUT);
      bias_ctrl_group0_o <= bias0_q;
      bias_ctrl_group1_o <= bias1_q;
      output_type_ctrl_o <= out_type_q;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_arm;
    wr_cmd && bus_i.wdata[CMD_ARM];
  endsequence

  a_sleep_no_arm: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_cmd && !armed_q && state_q == PDWK_RUN |=> state_q == PDWK_RUN)
    else $error("sleep op without arm changed state");
  a_arm_then_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_arm ##1 (wr_cmd && bus_i.wdata[CMD_HOLD] && state_q == PDWK_RUN)
    |=> state_q == PDWK_SLEEP_HOLD ##1 stack_level_init_o == 3'h7)
    else $error("hold sleep not entered after arm");
  a_warm_on_wake: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wake |=> warm_q ##1 warm_start_o)
    else $error("warm indicator not set by wake");
  a_hold_no_t3: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_q == PDWK_SLEEP_HOLD && !key_wake && !int_lvl_wake
    && !int_edge_wake |=> state_q == PDWK_SLEEP_HOLD)
    else $error("hold sleep left without key wake");
  a_t3_wakes: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_q == PDWK_SLEEP_CLK && t3f_q |=> state_q == PDWK_RUN)
    else $error("timer 3 flag did not wake");
  a_init_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sleep_cmd |=> init_o.cpu_init && init_o.wdog_init
    && init_o.irq_init)
    else $error("sleep entry did not initialise core");
  a_lvl_no_ext0: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_q != PDWK_RUN && int_lvl_wake && !ext0f_q
    |=> !ext0f_q)
    else $error("level wake set ext0 flag");
  a_cnt_pin_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_q == PDWK_SLEEP_HOLD && $stable(state_q)
    |=> counter_io_pin_oe_o == (cnt_sel_q != CNT_SEL_INPUT))
    else $error("counter pin drive wrong in hold");
  a_bo_unarmed: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_q != PDWK_RUN && !bo_arm_q |=> !brownout_active_o)
    else $error("brownout active in sleep unarmed");
  a_t3_kept: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_q == PDWK_SLEEP_CLK && t3f_q && !wr_cmd |=> t3f_q)
    else $error("timer 3 flag lost at clock-run wake");

endmodule : pdwk_ctrl

// ===== verif/pdwk_keys.sv
// Key switch and interrupt source model facing the wake inputs
`timescale 1ns/1ps
module pdwk_keys
(
  input wire logic ref_clk_i,
  input wire logic [3:0] press0_i,
  input wire logic [3:0] press1_i,
  input wire logic int_act_i,
  output logic [3:0] port_group_0_o = 4'hf,
  output logic [3:0] port_group_1_o = 4'hf,
  output logic int_pin_o = 1'b0
);
  // ----------------------------------------------------------------
  // Key lines
  // ----------------------------------------------------------------
  // Pressed keys pull low, pull-ups hold released lines high
  always @(posedge ref_clk_i)
  begin
    port_group_0_o <= ~press0_i;
    port_group_1_o <= ~press1_i;
    int_pin_o <= int_act_i;
  end
endmodule : pdwk_keys

// ===== verif/test_power_down_wakeup_control.sv
// Self-checking bench for the power-down and wakeup controller
`timescale 1ns/1ps
module test_power_down_wakeup_control
  import pdwk_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  pdwk_bus_type bus = '0;
  logic [3:0] press0 = 4'h0;
  logic [3:0] press1 = 4'h0;
  logic int_act = 1'b0;
  logic t3u = 1'b0;
  logic [7:0] rdata_o;
  pdwk_init_type init_o;
  logic [4:0] init_seen = '0;
  logic [2:0] stack_level_init_o;
  logic sleeping_o, osc_stop_o, warm_start_o, t3f_o, bo_o, cpin, cpin_oe;
  logic [3:0] pg0, pg1, bias0, bias1, otype;
  logic int_pin;
  int fail_count = 0;
  int check_count = 0;
  logic [7:0] v;

  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  always #4 ref_clk_i = ~ref_clk_i;
  // Collect init pulses since the last arm command
  always @(posedge ref_clk_i)
    init_seen <= (bus.wr && bus.addr == ADDR_CMD && bus.wdata[CMD_ARM])
                 ? '0 : (init_seen | init_o);

  pdwk_ctrl DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_i(bus),
    .rdata_o(rdata_o), .port_group_0_i(pg0), .port_group_1_i(pg1),
    .int_pin_i(int_pin), .timer3_underflow_i(t3u), .init_o(init_o),
    .stack_level_init_o(stack_level_init_o), .sleeping_o(sleeping_o),
    .osc_stop_o(osc_stop_o), .warm_start_o(warm_start_o),
    .timer3_request_flag_o(t3f_o), .brownout_active_o(bo_o),
    .counter_io_pin_o(cpin), .counter_io_pin_oe_o(cpin_oe),
    .bias_ctrl_group0_o(bias0), .bias_ctrl_group1_o(bias1),
    .output_type_ctrl_o(otype));

  pdwk_keys keys (.ref_clk_i(ref_clk_i), .press0_i(press0),
    .press1_i(press1), .int_act_i(int_act), .port_group_0_o(pg0),
    .port_group_1_o(pg1), .int_pin_o(int_pin));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    #1;
    d = rdata_o;
  endtask : rd

  task automatic tick(input int n);
    bus <= '0;
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick

  // Kick watchdog and clear timer 3 flag first when clean is set
  task automatic sleep(input logic [7:0] mode, input logic clean);
    if (clean)
      wr(ADDR_CMD, 8'h48);
    wr(ADDR_CMD, 8'h01);
    wr(ADDR_CMD, mode);
    tick(2);
  endtask : sleep

  task automatic wake_wait(input int lim);
    for (int i = 0; i < lim; i++)
    begin
      if (sleeping_o === 1'b0)
        break;
      @(posedge ref_clk_i);
      #1;
    end
    chk("awake", 8'h00, sleeping_o);
    if (sleeping_o !== 1'b0)
      test_done();
    tick(2);
  endtask : wake_wait

  task automatic t3_pulse();
    t3u <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    t3u <= 1'b0;
  endtask : t3_pulse

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    chk("warm", 8'h00, warm_start_o);
    chk("brownout", 8'h01, bo_o);
    foreach (v[i])
    begin
      rd(4'(i), v);
      chk("reset reg", 8'h00, v);
    end
    rd(ADDR_CNT_SEL, v);
    chk("cnt sel", 8'h00, v);
    rd(4'hf, v);
    chk("unmapped", 8'h00, v);
  endtask : s_reset

  task automatic s_regs();
    for (int a = 0; a < 7; a++)
      wr(4'(a), 8'(a + 9));
    for (int a = 0; a < 7; a++)
    begin
      rd(4'(a), v);
      chk("readback", 8'(a + 9), v);
    end
    chk("bias0", 8'h0d, bias0);
    chk("bias1", 8'h0e, bias1);
    chk("out type", 8'h0f, otype);
    for (int a = 0; a < 4; a++)
      wr(4'(a), 8'h00);
  endtask : s_regs

  task automatic s_noarm();
    wr(ADDR_CMD, 8'h02);
    wr(ADDR_CMD, 8'h01);
    wr(ADDR_CMD, 8'h08);
    wr(ADDR_CMD, 8'h04);
    tick(3);
    chk("no sleep", 8'h00, sleeping_o);
  endtask : s_noarm

  task automatic s_clkrun();
    sleep(8'h02, 1'b1);
    chk("asleep", 8'h01, sleeping_o);
    chk("osc", 8'h00, osc_stop_o);
    chk("stack", 8'h00, stack_level_init_o);
    chk("init", 8'h1e, init_seen);
    chk("bo off", 8'h00, bo_o);
    rd(ADDR_STATUS, v);
    chk("status", 8'h04, v);
    press0 <= 4'h1;
    tick(4);
    chk("key off", 8'h01, sleeping_o);
    press0 <= 4'h0;
    t3_pulse();
    wake_wait(4);
    chk("warm", 8'h01, warm_start_o);
    rd(ADDR_STATUS, v);
    chk("status", 8'h03, v);
  endtask : s_clkrun

  task automatic s_hold(input logic [7:0] sel, input logic [7:0] oe);
    wr(ADDR_CNT_SEL, sel);
    wr(ADDR_WAKE_EN, 8'h01);
    rd(ADDR_CNT_SEL, v);
    chk("cnt sel", sel, v);
    sleep(8'h04, 1'b1);
    chk("stack", 8'h07, stack_level_init_o);
    chk("osc", 8'h01, osc_stop_o);
    chk("init", 8'h1f, init_seen);
    chk("cnt oe", oe, cpin_oe);
    if (oe[0])
      chk("cnt pin", 8'h00, cpin);
    rd(ADDR_STATUS, v);
    chk("status", 8'h09, v);
    t3_pulse();
    tick(4);
    chk("t3 ignored", 8'h01, sleeping_o);
    press0 <= 4'h2;
    wake_wait(4);
    press0 <= 4'h0;
    chk("bias0", 8'h0d, bias0);
    chk("out type", 8'h0f, otype);
    rd(ADDR_WAKE_EN, v);
    chk("wake en", 8'h01, v);
  endtask : s_hold

  task automatic s_t3imm();
    wr(ADDR_CMD, 8'h20);
    sleep(8'h02, 1'b0);
    wake_wait(4);
    chk("init", 8'h1e, init_seen);
    chk("t3f", 8'h01, t3f_o);
  endtask : s_t3imm

  task automatic s_level();
    wr(ADDR_WAKE_EN, 8'h04);
    wr(ADDR_WAKE_COND, 8'h02);
    sleep(8'h02, 1'b1);
    press1 <= 4'h1;
    wake_wait(4);
    press1 <= 4'h0;
    wr(ADDR_WAKE_EN, 8'h00);
    wr(ADDR_EXT_WAKE, 8'h01);
    wr(ADDR_EXT_IRQ, 8'h06);
    sleep(8'h04, 1'b1);
    int_act <= 1'b1;
    wake_wait(4);
    rd(ADDR_STATUS, v);
    chk("ext0 flag", 8'h00, v & 8'h20);
    int_act <= 1'b0;
  endtask : s_level

  // Group 1 rising-edge pair and interrupt pin edge wake
  task automatic s_edge();
    wr(ADDR_EXT_WAKE, 8'h00);
    wr(ADDR_WAKE_EN, 8'h08);
    wr(ADDR_WAKE_COND, 8'h04);
    sleep(8'h02, 1'b1);
    press1 <= 4'h4;
    tick(4);
    chk("fall ignored", 8'h01, sleeping_o);
    press1 <= 4'h0;
    wake_wait(4);
    wr(ADDR_WAKE_EN, 8'h00);
    wr(ADDR_EXT_WAKE, 8'h03);
    sleep(8'h04, 1'b1);
    int_act <= 1'b1;
    wake_wait(4);
    rd(ADDR_STATUS, v);
    chk("ext0 edge", 8'h20, v & 8'h20);
    int_act <= 1'b0;
  endtask : s_edge

  task automatic s_bo();
    wr(ADDR_CMD, 8'h10);
    rd(ADDR_STATUS, v);
    chk("bo armed", 8'h10, v & 8'h10);
    sleep(8'h02, 1'b1);
    chk("bo on", 8'h01, bo_o);
    t3_pulse();
    wake_wait(4);
  endtask : s_bo

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    s_reset();
    s_regs();
    s_noarm();
    s_clkrun();
    s_hold(8'h00, 8'h01);
    s_hold(8'h03, 8'h00);
    s_t3imm();
    s_level();
    s_edge();
    s_bo();
    test_done();
  end
endmodule : test_power_down_wakeup_control
